// *** core/ptl_capture_hold.sv ***
`timescale 1ns/10ps
module ptl_capture_hold #(
    parameter int W = 64
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_clk_en,
    input  wire logic         i_capture,
    input  wire logic         i_lock_en,
    input  wire logic         i_pending,
    input  wire logic [W-1:0] i_data,
    output logic      [W-1:0] o_held
);
    import ptl_pkg::*;

    // ------------------------------------------------------------
    // Lock gate
    // ------------------------------------------------------------
    // Capture refused while locked and a previous one is unacknowledged
    wire take = i_capture & ~(i_lock_en & i_pending);

    // Stored value
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_held <= '0;
        end else if (i_clk_en && take) begin
            o_held <= i_data;
        end
    end
endmodule

// *** core/ptl_event_out.sv ***
`timescale 1ns/10ps
module ptl_event_out (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_clk_en,
    input  wire logic                   i_event,
    input  wire ptl_pkg::ptl_evt_mode_t i_mode,
    input  wire logic                   i_out_en,
    input  wire logic                   i_polarity,
    input  wire logic                   i_timer_flag,
    output logic                        o_pin_out,
    output logic                        o_pin_oe
);
    import ptl_pkg::*;

    logic [1:0] pulse_cnt_r;
    logic       toggle_r;
    logic       level_r;

    // ------------------------------------------------------------
    // Pulse counter and toggle state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pulse_cnt_r <= 2'h0;
            toggle_r    <= 1'b0;
        end else if (i_clk_en) begin
            if (i_event && i_mode == PTL_EVT_PULSE) begin
                pulse_cnt_r <= PULSE_CYC;
            end else if (pulse_cnt_r != 2'h0) begin
                pulse_cnt_r <= pulse_cnt_r - 2'h1;
            end
            if (i_event && i_mode == PTL_EVT_TOGGLE) begin
                toggle_r <= ~toggle_r;
            end
        end
    end

    // Active level by mode, reserved drives inactive
    always_comb begin
        case (i_mode)
            PTL_EVT_PULSE:  level_r = (pulse_cnt_r != 2'h0);
            PTL_EVT_TOGGLE: level_r = toggle_r;
            PTL_EVT_LEVEL:  level_r = i_timer_flag;
            default:        level_r = 1'b0;
        endcase
    end

    // Registered pin drive with polarity and enable
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= 1'b0;
        end else if (i_clk_en) begin
            o_pin_out <= i_out_en & (i_polarity ? level_r : ~level_r);
            o_pin_oe  <= i_out_en;
        end
    end
endmodule

// *** core/ptl_pkg.sv ***
package ptl_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 9;
    localparam logic [8:0]  OFS_CONFIG      = 9'h180;
    localparam logic [8:0]  OFS_TGT_UPPER   = 9'h184;
    localparam logic [8:0]  OFS_TGT_LOWER   = 9'h188;
    localparam logic [8:0]  OFS_RLD_UPPER   = 9'h18c;
    localparam logic [8:0]  OFS_RLD_LOWER   = 9'h190;
    localparam logic [8:0]  OFS_STS_EN      = 9'h198;
    localparam logic [8:0]  OFS_MII_CLK_HI  = 9'h1a0;
    localparam logic [8:0]  OFS_MII_CLK_LO  = 9'h1a4;
    localparam logic [8:0]  OFS_MII_SEQ_UID = 9'h1a8;
    localparam logic [8:0]  OFS_MII_UID_LO  = 9'h1ac;
    localparam logic [8:0]  OFS_PA_CLK_HI   = 9'h1b0;
    localparam logic [8:0]  OFS_PA_CLK_LO   = 9'h1b4;
    localparam logic [8:0]  OFS_PB_CLK_HI   = 9'h1b8;
    localparam logic [8:0]  OFS_PB_CLK_LO   = 9'h1bc;
    localparam logic [8:0]  OFS_PIN_CFG     = 9'h1c0;

    // ------------------------------------------------------------
    // Config register fields and reset
    // ------------------------------------------------------------
    localparam int          CFG_LOCK_TX     = 8;
    localparam int          CFG_LOCK_B      = 6;
    localparam int          CFG_LOCK_A      = 5;
    localparam int          CFG_MODE_B_HI   = 4;
    localparam int          CFG_MODE_B_LO   = 3;
    localparam int          CFG_MODE_A_HI   = 2;
    localparam int          CFG_MODE_A_LO   = 1;
    localparam int          CFG_RELOAD_ADD  = 0;
    localparam logic [31:0] CFG_RST         = 32'h0000_0160;
    localparam logic [31:0] CFG_RW_MASK     = 32'h0000_017f;

    // ------------------------------------------------------------
    // Status / enable fields
    // ------------------------------------------------------------
    localparam int          STS_TIMER       = 0;
    localparam int          STS_PIN_A       = 1;
    localparam int          STS_PIN_B       = 2;
    localparam int          STS_MII_TX      = 3;
    localparam int          STS_MII_RX      = 4;
    localparam int          EN_SHIFT        = 16;
    localparam logic [4:0]  STS_RST         = 5'h00;
    localparam logic [4:0]  EN_RST          = 5'h00;

    // ------------------------------------------------------------
    // Pin configuration fields
    // ------------------------------------------------------------
    localparam int          PIN_OE_A        = 8;
    localparam int          PIN_OE_B        = 9;
    localparam int          PIN_POL_A       = 16;
    localparam int          PIN_POL_B       = 17;
    localparam int          PIN_BUF_A       = 24;
    localparam int          PIN_BUF_B       = 25;
    localparam logic [31:0] PIN_RW_MASK     = 32'h0301_0300 | 32'h0002_0000;
    localparam logic [31:0] PIN_CFG_RST     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Event modes and timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTL_EVT_PULSE  = 2'h0,
        PTL_EVT_TOGGLE = 2'h1,
        PTL_EVT_LEVEL  = 2'h2,
        PTL_EVT_RSVD   = 2'h3
    } ptl_evt_mode_t;

    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          PULSE_NS        = 100;
    localparam int          PULSE_CYC_INT   = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  PULSE_CYC       = 2'(PULSE_CYC_INT);

    // Capture widths
    localparam int          CLK_W           = 64;
    localparam int          UID_W           = 48;
    localparam int          SEQ_W           = 16;
    localparam int          MII_W           = CLK_W + UID_W + SEQ_W;

endpackage

// *** core/ptl_top.sv ***
`timescale 1ns/10ps
module ptl_top (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_clk_en,
    // Avalon-MM slave
    input  wire logic [ptl_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                       i_avs_read,
    input  wire logic                       i_avs_write,
    input  wire logic [31:0]                i_avs_writedata,
    input  wire logic [3:0]                 i_avs_byteenable,
    output logic      [31:0]                o_avs_readdata,
    output logic                            o_avs_waitrequest,
    // Time clock from the clock unit
    input  wire logic [ptl_pkg::CLK_W-1:0]  i_time_clock,
    // External port captures
    input  wire logic                       i_port_to_fabric_capture,
    input  wire logic                       i_fabric_to_port_capture,
    input  wire logic [ptl_pkg::UID_W-1:0]  i_source_uuid,
    input  wire logic [ptl_pkg::SEQ_W-1:0]  i_sequence_id,
    // Time pins
    input  wire logic                       i_pin_a_in,
    input  wire logic                       i_pin_b_in,
    output logic                            o_pin_a_out,
    output logic                            o_pin_a_oe,
    output logic                            o_pin_b_out,
    output logic                            o_pin_b_oe,
    output logic      [1:0]                 o_pin_buffer_type
);
    import ptl_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]        config_r;
    logic [31:0]        pin_cfg_r;
    logic [31:0]        target_upper_r;
    logic [31:0]        target_lower_r;
    logic [31:0]        reload_upper_r;
    logic [31:0]        reload_lower_r;
    logic [4:0]         status_r;
    logic [4:0]         enable_r;
    logic               done_r;
    logic [31:0]        readdata_r;
    logic               pin_a_d_r;
    logic               pin_b_d_r;
    logic [MII_W-1:0]   mii_held;
    logic [CLK_W-1:0]   pin_a_held;
    logic [CLK_W-1:0]   pin_b_held;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait cycle per access, then the access completes
    wire        req      = i_avs_read | i_avs_write;
    wire        wr_fire  = i_avs_write & done_r;
    wire        rd_latch = i_avs_read & ~done_r;
    assign o_avs_waitrequest = req & ~done_r;
    assign o_avs_readdata    = readdata_r;

    wire [31:0] be_mask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                            {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    wire [31:0] wmask    = wr_fire ? be_mask : 32'h0000_0000;

    // Address decode
    wire hit_cfg    = (i_avs_address == OFS_CONFIG);
    wire hit_tgt_u  = (i_avs_address == OFS_TGT_UPPER);
    wire hit_tgt_l  = (i_avs_address == OFS_TGT_LOWER);
    wire hit_rld_u  = (i_avs_address == OFS_RLD_UPPER);
    wire hit_rld_l  = (i_avs_address == OFS_RLD_LOWER);
    wire hit_sts    = (i_avs_address == OFS_STS_EN);
    wire hit_mii_h  = (i_avs_address == OFS_MII_CLK_HI);
    wire hit_mii_l  = (i_avs_address == OFS_MII_CLK_LO);
    wire hit_mii_s  = (i_avs_address == OFS_MII_SEQ_UID);
    wire hit_mii_u  = (i_avs_address == OFS_MII_UID_LO);
    wire hit_pa_h   = (i_avs_address == OFS_PA_CLK_HI);
    wire hit_pa_l   = (i_avs_address == OFS_PA_CLK_LO);
    wire hit_pb_h   = (i_avs_address == OFS_PB_CLK_HI);
    wire hit_pb_l   = (i_avs_address == OFS_PB_CLK_LO);
    wire hit_pin    = (i_avs_address == OFS_PIN_CFG);

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    // Target compare, equal or passed
    wire [63:0] target   = {target_upper_r, target_lower_r};
    wire        cmp_evt  = (i_time_clock >= target);
    wire [63:0] tgt_add  = target + {32'h0000_0000, reload_lower_r};
    wire [63:0] tgt_nxt  = config_r[CFG_RELOAD_ADD]
                           ? {reload_upper_r, reload_lower_r}
                           : tgt_add;

    // Pin rising edges
    wire        pin_a_evt = i_pin_a_in & ~pin_a_d_r;
    wire        pin_b_evt = i_pin_b_in & ~pin_b_d_r;

    // Port 0 direction: transmit enters fabric, receive leaves it
    wire        mii_tx_evt = i_port_to_fabric_capture;
    wire        mii_rx_evt = i_fabric_to_port_capture;

    // Status set and clear, set wins over clear
    wire [4:0]  sts_set  = {mii_rx_evt, mii_tx_evt, pin_b_evt, pin_a_evt, cmp_evt};
    wire [4:0]  sts_clr  = hit_sts ? (i_avs_writedata[4:0] & wmask[4:0]) : 5'h00;
    wire [4:0]  sts_nxt  = (status_r & ~sts_clr) | sts_set;

    wire [4:0]  en_wmask = hit_sts ? wmask[EN_SHIFT+4:EN_SHIFT] : 5'h00;
    wire [4:0]  en_nxt   = (enable_r & ~en_wmask)
                           | (i_avs_writedata[EN_SHIFT+4:EN_SHIFT] & en_wmask);

    wire [31:0] cfg_wm   = hit_cfg ? (wmask & CFG_RW_MASK) : 32'h0000_0000;
    wire [31:0] cfg_nxt  = (config_r & ~cfg_wm) | (i_avs_writedata & cfg_wm);
    wire [31:0] pin_wm   = hit_pin ? (wmask & PIN_RW_MASK) : 32'h0000_0000;
    wire [31:0] pin_nxt  = (pin_cfg_r & ~pin_wm) | (i_avs_writedata & pin_wm);

    // ------------------------------------------------------------
    // Read mux, unmapped reads as zero
    // ------------------------------------------------------------
    wire [31:0] sts_word = {11'h000, enable_r, 11'h000, status_r};
    wire [31:0] rd_mux =
          ({32{hit_cfg}}   & config_r)
        | ({32{hit_tgt_u}} & target_upper_r)
        | ({32{hit_tgt_l}} & target_lower_r)
        | ({32{hit_rld_u}} & reload_upper_r)
        | ({32{hit_rld_l}} & reload_lower_r)
        | ({32{hit_sts}}   & sts_word)
        | ({32{hit_mii_h}} & mii_held[127:96])
        | ({32{hit_mii_l}} & mii_held[95:64])
        | ({32{hit_mii_s}} & mii_held[63:32])
        | ({32{hit_mii_u}} & mii_held[31:0])
        | ({32{hit_pa_h}}  & pin_a_held[63:32])
        | ({32{hit_pa_l}}  & pin_a_held[31:0])
        | ({32{hit_pb_h}}  & pin_b_held[63:32])
        | ({32{hit_pb_l}}  & pin_b_held[31:0])
        | ({32{hit_pin}}   & pin_cfg_r);

    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_r     <= 1'b0;
            readdata_r <= 32'h0000_0000;
        end else if (i_clk_en) begin
            done_r <= req & ~done_r;
            if (rd_latch) begin
                readdata_r <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            config_r  <= CFG_RST;
            pin_cfg_r <= PIN_CFG_RST;
            status_r  <= STS_RST;
            enable_r  <= EN_RST;
        end else if (i_clk_en) begin
            config_r  <= cfg_nxt;
            pin_cfg_r <= pin_nxt;
            status_r  <= sts_nxt;
            enable_r  <= en_nxt;
        end
    end

    // Target and reload, compare update wins over a software write
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            target_upper_r <= 32'h0000_0000;
            target_lower_r <= 32'h0000_0000;
            reload_upper_r <= 32'h0000_0000;
            reload_lower_r <= 32'h0000_0000;
        end else if (i_clk_en) begin
            if (cmp_evt) begin
                target_upper_r <= tgt_nxt[63:32];
                target_lower_r <= tgt_nxt[31:0];
            end else begin
                target_upper_r <= (target_upper_r & ~(hit_tgt_u ? wmask : 32'h0))
                                | (i_avs_writedata & (hit_tgt_u ? wmask : 32'h0));
                target_lower_r <= (target_lower_r & ~(hit_tgt_l ? wmask : 32'h0))
                                | (i_avs_writedata & (hit_tgt_l ? wmask : 32'h0));
            end
            reload_upper_r <= (reload_upper_r & ~(hit_rld_u ? wmask : 32'h0))
                            | (i_avs_writedata & (hit_rld_u ? wmask : 32'h0));
            reload_lower_r <= (reload_lower_r & ~(hit_rld_l ? wmask : 32'h0))
                            | (i_avs_writedata & (hit_rld_l ? wmask : 32'h0));
        end
    end

    // Pin edge history
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_a_d_r <= 1'b0;
            pin_b_d_r <= 1'b0;
        end else if (i_clk_en) begin
            pin_a_d_r <= i_pin_a_in;
            pin_b_d_r <= i_pin_b_in;
        end
    end

    // ------------------------------------------------------------
    // Capture holders
    // ------------------------------------------------------------
    ptl_capture_hold #(.W(MII_W)) u_mii_tx_hold (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_capture (mii_tx_evt),
        .i_lock_en (config_r[CFG_LOCK_TX]),
        .i_pending (status_r[STS_MII_TX]),
        .i_data    ({i_time_clock, i_sequence_id, i_source_uuid}),
        .o_held    (mii_held)
    );

    ptl_capture_hold #(.W(CLK_W)) u_pin_a_hold (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_capture (pin_a_evt),
        .i_lock_en (config_r[CFG_LOCK_A]),
        .i_pending (status_r[STS_PIN_A]),
        .i_data    (i_time_clock),
        .o_held    (pin_a_held)
    );

    ptl_capture_hold #(.W(CLK_W)) u_pin_b_hold (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_capture (pin_b_evt),
        .i_lock_en (config_r[CFG_LOCK_B]),
        .i_pending (status_r[STS_PIN_B]),
        .i_data    (i_time_clock),
        .o_held    (pin_b_held)
    );

    // ------------------------------------------------------------
    // Pin event outputs
    // ------------------------------------------------------------
    ptl_event_out u_pin_a_evt (
        .i_clk        (i_clk),
        .i_reset_n    (i_reset_n),
        .i_clk_en     (i_clk_en),
        .i_event      (cmp_evt),
        .i_mode       (ptl_evt_mode_t'(config_r[CFG_MODE_A_HI:CFG_MODE_A_LO])),
        .i_out_en     (pin_cfg_r[PIN_OE_A]),
        .i_polarity   (pin_cfg_r[PIN_POL_A]),
        .i_timer_flag (status_r[STS_TIMER]),
        .o_pin_out    (o_pin_a_out),
        .o_pin_oe     (o_pin_a_oe)
    );

    ptl_event_out u_pin_b_evt (
        .i_clk        (i_clk),
        .i_reset_n    (i_reset_n),
        .i_clk_en     (i_clk_en),
        .i_event      (cmp_evt),
        .i_mode       (ptl_evt_mode_t'(config_r[CFG_MODE_B_HI:CFG_MODE_B_LO])),
        .i_out_en     (pin_cfg_r[PIN_OE_B]),
        .i_polarity   (pin_cfg_r[PIN_POL_B]),
        .i_timer_flag (status_r[STS_TIMER]),
        .o_pin_out    (o_pin_b_out),
        .o_pin_oe     (o_pin_b_oe)
    );

    // Buffer type passes straight to the pad
    assign o_pin_buffer_type = {pin_cfg_r[PIN_BUF_B], pin_cfg_r[PIN_BUF_A]};

endmodule

// *** dv/ptl_chk.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module ptl_chk (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_clk_en,
    input wire logic [8:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_pin_a_out,
    input wire logic        o_pin_a_oe,
    input wire logic        o_pin_b_out,
    input wire logic        o_pin_b_oe
);
    import ptl_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Pending request and completed read
    sequence s_req;
        (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en;
    endsequence
    sequence s_rd(logic [8:0] a);
        i_avs_read && !o_avs_waitrequest && i_avs_address == a;
    endsequence
    // Bus handshake
    chk_one_wait: assert property (s_req |=> !o_avs_waitrequest)
        else $error("bus wait exceeds one cycle");
    chk_idle_ready: assert property (!i_avs_read && !i_avs_write |-> !o_avs_waitrequest)
        else $error("waitrequest without request");
    chk_rd_hold: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
        else $error("read data moved without read");
    // Register read contents
    chk_unmapped_zero: assert property (s_rd(9'h194) |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_sts_rsvd: assert property (s_rd(OFS_STS_EN) |-> (o_avs_readdata & 32'hffe0_ffe0) == 0)
        else $error("status reserved bits set");
    chk_cfg_rsvd: assert property (s_rd(OFS_CONFIG) |-> (o_avs_readdata & ~CFG_RW_MASK) == 0)
        else $error("config reserved bits set");
    // Pins stay quiet while not enabled
    chk_pin_a_off: assert property (!o_pin_a_oe |-> !o_pin_a_out)
        else $error("pin a driven while disabled");
    chk_pin_b_off: assert property (!o_pin_b_oe |-> !o_pin_b_out)
        else $error("pin b driven while disabled");
endmodule
bind ptl_top ptl_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_pin_a_out(o_pin_a_out), .o_pin_a_oe(o_pin_a_oe), .o_pin_b_out(o_pin_b_out),
    .o_pin_b_oe(o_pin_b_oe));

// *** dv/ptl_far_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far side: time source, port captures, pins
// ------------------------------------------------------------
module ptl_far_model #(
    parameter logic [47:0] UUID = 48'h0a1b_2c3d_4e5f
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_req,
    output logic      [63:0] o_time,
    output logic             o_tx_cap,
    output logic             o_rx_cap,
    output logic             o_pin_a,
    output logic             o_pin_b,
    output logic      [47:0] o_uuid,
    output logic      [15:0] o_seq
);
    logic [1:0]  req_d_r;
    logic [15:0] seq_r;
    // Ids valid only with the transmit pulse, garbage otherwise
    assign o_uuid = o_tx_cap ? UUID : ~UUID;
    assign o_seq  = o_tx_cap ? seq_r : ~seq_r;
    // Running time, one capture pulse per request rise, pins follow the request level
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {o_time, o_tx_cap, o_rx_cap, o_pin_a, o_pin_b, req_d_r, seq_r} <= '0;
        end else begin
            o_time             <= o_time + 64'h1;
            o_tx_cap           <= i_req[0] & ~req_d_r[0];
            o_rx_cap           <= i_req[1] & ~req_d_r[1];
            req_d_r            <= i_req[1:0];
            {o_pin_b, o_pin_a} <= i_req[3:2];
            seq_r              <= seq_r + {15'h0, o_tx_cap};
        end
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb_top;
    import ptl_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, rd = 0, wr = 0, wq, txc, rxc, pa, pb, pao, paoe, pbo, pboe;
    logic [8:0] adr = '0;
    logic [31:0] wd = '0, rdat, q;
    logic [3:0] be = 4'hf, rq = '0;
    logic [1:0] bt;
    logic [63:0] tm;
    logic [47:0] uid;
    logic [15:0] sq;
    int fails = 0, tests_run = 0;
    always #20 clk = ~clk;
    ptl_far_model FAR (.i_clk(clk), .i_reset_n(rst_n), .i_req(rq), .o_time(tm), .o_tx_cap(txc),
        .o_rx_cap(rxc), .o_pin_a(pa), .o_pin_b(pb), .o_uuid(uid), .o_seq(sq));
    ptl_top DUT (.i_clk(clk), .i_reset_n(rst_n), .i_clk_en(ce), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_time_clock(tm),
        .i_port_to_fabric_capture(txc), .i_fabric_to_port_capture(rxc), .i_source_uuid(uid),
        .i_sequence_id(sq), .i_pin_a_in(pa), .i_pin_b_in(pb), .o_pin_a_out(pao),
        .o_pin_a_oe(paoe), .o_pin_b_out(pbo), .o_pin_b_oe(pboe), .o_pin_buffer_type(bt));
    // Verdict and compare helpers
    task automatic end_sim;
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask
    // Bus cycle held until waitrequest seen low
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d, input logic [3:0] m);
        @(posedge clk);
        {rd, wr, adr, wd, be} <= {~w, w, a, d, m};
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        {rd, wr} <= 2'b00;
    endtask
    task automatic w32(input logic [8:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 4'hf);
    endtask
    task automatic rc(input logic [8:0] a, input logic [31:0] e, input string n);
        acc(1'b0, a, 32'h0, 4'hf);
        ck(n, e, q);
    endtask
    // Far-side request held three cycles, then released
    task automatic fire(input int k);
        @(posedge clk);
        rq[k] <= 1'b1;
        repeat (3) @(posedge clk);
        rq[k] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // Reset values, field access, clearing
    task automatic t_regs;
        rc(OFS_STS_EN, 32'h1, "sts_rst");
        rc(OFS_CONFIG, 32'h160, "cfg_rst");
        rc(OFS_PIN_CFG, 32'h0, "pin_rst");
        rc(9'h194, 32'h0, "unmapped");
        w32(OFS_RLD_UPPER, 32'hffff_ffff);
        w32(OFS_CONFIG, 32'h161);
        rc(OFS_TGT_UPPER, 32'hffff_ffff, "reload");
        w32(OFS_CONFIG, 32'hffff_ffff);
        rc(OFS_CONFIG, 32'h17f, "cfg_rw");
        w32(OFS_CONFIG, 32'h160);
        w32(OFS_STS_EN, 32'h001f_001f);
        rc(OFS_STS_EN, 32'h001f_0000, "sts_clr");
    endtask
    // Transmit capture lock and direction
    task automatic t_tx;
        fire(0);
        rc(OFS_MII_SEQ_UID, 32'h0000_0a1b, "seq1");
        rc(OFS_MII_UID_LO, 32'h2c3d_4e5f, "uid");
        fire(1);
        rc(OFS_STS_EN, 32'h001f_0018, "rx_tx");
        fire(0);
        rc(OFS_MII_SEQ_UID, 32'h0000_0a1b, "locked");
        acc(1'b1, OFS_STS_EN, 32'h0000_0008, 4'he);
        rc(OFS_STS_EN, 32'h0000_0018, "be_mask");
        w32(OFS_STS_EN, 32'h001f_0008);
        fire(0);
        rc(OFS_MII_SEQ_UID, 32'h0002_0a1b, "seq3");
        w32(OFS_CONFIG, 32'h060);
        fire(0);
        rc(OFS_MII_SEQ_UID, 32'h0003_0a1b, "unlock");
        w32(OFS_CONFIG, 32'h160);
        w32(OFS_STS_EN, 32'h001f_001f);
        ce <= 1'b0;
        fire(1);
        ce <= 1'b1;
        rc(OFS_STS_EN, 32'h001f_0000, "ce_hold");
    endtask
    // Pin capture locks
    task automatic t_pin;
        logic [31:0] v;
        logic [8:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? OFS_PB_CLK_LO : OFS_PA_CLK_LO;
            fire(2 + i);
            rc(OFS_STS_EN, 32'h001f_0000 | (32'h2 << i), "pin_sts");
            acc(1'b0, a, 32'h0, 4'hf);
            v = q;
            fire(2 + i);
            rc(a, v, "pin_lock");
            w32(OFS_STS_EN, 32'h001f_0006);
            fire(2 + i);
            acc(1'b0, a, 32'h0, 4'hf);
            ck("pin_new", 32'h1, {31'h0, q !== v});
            w32(OFS_STS_EN, 32'h001f_0006);
        end
    endtask
    // Target compare, pin event modes
    task automatic t_cmp;
        logic [31:0] tl;
        int n;
        w32(OFS_PIN_CFG, 32'h0001_0300);
        rc(OFS_PIN_CFG, 32'h0001_0300, "pincfg");
        ck("pins", 32'he, {pboe, paoe, pbo, pao});
        w32(OFS_RLD_LOWER, 32'd40);
        w32(OFS_RLD_UPPER, 32'h0);
        w32(OFS_CONFIG, 32'h168);
        tl = tm[31:0] + 32'd200;
        w32(OFS_TGT_LOWER, tl);
        w32(OFS_TGT_UPPER, 32'h0);
        n = 0;
        while (pao !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (pao === 1'b1 && n < 9) begin
            @(posedge clk);
            n++;
        end
        ck("pulse", 32'd3, n);
        ck("toggle", 32'h0, pbo);
        rc(OFS_TGT_LOWER, tl + 32'd40, "add");
        rc(OFS_STS_EN, 32'h001f_0001, "tmr");
        w32(OFS_CONFIG, 32'h169);
        w32(OFS_RLD_UPPER, 32'h2);
        repeat (60) @(posedge clk);
        rc(OFS_TGT_UPPER, 32'h2, "rld_hi");
        rc(OFS_TGT_LOWER, 32'd40, "rld_lo");
        w32(OFS_CONFIG, 32'h17d);
        rc(OFS_CONFIG, 32'h17d, "modes");
        ck("level", 32'h3, {pbo, pao});
        w32(OFS_STS_EN, 32'h001f_0001);
        rc(OFS_STS_EN, 32'h001f_0000, "sts0");
        ck("lvl_off", 32'h0, pao);
        w32(OFS_PIN_CFG, 32'h0300_0000);
        rc(OFS_PIN_CFG, 32'h0300_0000, "buf");
        ck("buf_oe", 32'hc, {bt, pboe, paoe});
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_tx;
        t_pin;
        t_cmp;
        end_sim;
    end
endmodule
